// ==== acsl_pkg.sv ====
// acsl_pkg: register map, field layout, reset values and timing counts
package acsl_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RESULT_OFS = 8'h0A;
	localparam logic [7:0] CTRL_OFS = 8'h0B;
	localparam logic [7:0] EVT_STATUS_OFS = 8'h0C;
	localparam logic [7:0] EVT_MASK_OFS = 8'h0D;

	// ----------------------------------------------------------------
	// control/status field positions
	// ----------------------------------------------------------------
	localparam int DONE_BIT = 7;
	localparam int RSVD_HI_BIT = 6;
	localparam int POWER_BIT = 5;
	localparam int ZERO_BIT = 4;
	localparam int RSVD_LO_BIT = 3;
	localparam int CHAN_MSB = 2;
	localparam int CHAN_LSB = 0;
	localparam int CHAN_W = CHAN_MSB - CHAN_LSB + 1;

	// event status / mask field position
	localparam int EVT_DONE_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] EVT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// timing, in mclk cycles
	// ----------------------------------------------------------------
	localparam int CONV_CYCLES = 64;
	// sampling is 31.5 cycles, held here in half cycles and rounded up
	localparam int SAMPLE_HALF_CYCLES = 63;
	localparam int SAMPLE_CYCLES = (SAMPLE_HALF_CYCLES + 1) / 2;
	localparam int RESULT_W = 8;
	localparam int TRIAL_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / RESULT_W;
	localparam int CNT_W = $clog2(CONV_CYCLES);

	// sequencer states
	typedef enum logic [1:0]
	{
		ACSL_IDLE = 2'b00,
		ACSL_SAMPLE = 2'b01,
		ACSL_TRIAL = 2'b10
	} acsl_state_e;

endpackage : acsl_pkg

// ==== acsl_sar.sv ====
// acsl_sar: successive-approximation trial code register
`timescale 1ns/10ps
module acsl_sar
#(
	parameter int WIDTH = 8
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic decide,
	input wire logic [$clog2(WIDTH)-1:0] bit_idx,
	input wire logic comp_high,
	output logic [WIDTH-1:0] code,
	output logic [WIDTH-1:0] decided
);

	logic [WIDTH-1:0] code_reg;
	logic [WIDTH-1:0] code_next;
	logic [WIDTH-1:0] bit_mask;
	logic [WIDTH-1:0] next_mask;

	// ----------------------------------------------------------------
	// trial step
	// ----------------------------------------------------------------
	assign bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << bit_idx;
	assign next_mask = bit_mask >> 1;
	// keep the trial bit when the input stands at or above the trial
	assign decided = comp_high ? code_reg : (code_reg & ~bit_mask);
	assign code_next = start ? {1'b1, {(WIDTH-1){1'b0}}} :
		decide ? (decided | next_mask) : code_reg;
	assign code = code_reg;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			code_reg <= '0;
		else
			code_reg <= code_next;
	end

endmodule : acsl_sar

// ==== acsl_top.sv ====
// acsl_top: converter control, status and result logic
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module acsl_top
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	output logic irq,
	output logic conv_power_on,
	output logic [acsl_pkg::CHAN_W-1:0] input_channel_select,
	output logic sample_hold,
	output logic [acsl_pkg::RESULT_W-1:0] trial_code,
	input wire logic comp_high
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic srst_b;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign srst_b = rst_sync_reg;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire sel_result = (addr == acsl_pkg::RESULT_OFS);
	wire sel_ctrl = (addr == acsl_pkg::CTRL_OFS);
	wire sel_status = (addr == acsl_pkg::EVT_STATUS_OFS);
	wire sel_mask = (addr == acsl_pkg::EVT_MASK_OFS);
	wire wr_ctrl = wr_en && sel_ctrl;
	wire wr_status = wr_en && sel_status;
	wire wr_mask = wr_en && sel_mask;
	wire rd_result = rd_en && sel_result;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	logic power_reg;
	logic [acsl_pkg::CHAN_W-1:0] chan_reg;
	logic done_reg;
	logic done_next;
	logic [acsl_pkg::RESULT_W-1:0] result_reg;
	logic [acsl_pkg::RESULT_W-1:0] result_next;
	logic evt_reg;
	logic evt_next;
	logic mask_reg;

	always_ff @(posedge mclk or negedge srst_b)
	begin
		if (!srst_b)
		begin
			power_reg <= acsl_pkg::CTRL_RESET[acsl_pkg::POWER_BIT];
			chan_reg <= acsl_pkg::CTRL_RESET[acsl_pkg::CHAN_MSB:0];
		end
		else if (wr_ctrl)
		begin
			power_reg <= wdata[acsl_pkg::POWER_BIT];
			chan_reg <= wdata[acsl_pkg::CHAN_MSB:acsl_pkg::CHAN_LSB];
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	acsl_pkg::acsl_state_e state_reg;
	acsl_pkg::acsl_state_e state_next;
	logic [acsl_pkg::CNT_W-1:0] cnt_reg;
	logic [acsl_pkg::CNT_W-1:0] cnt_next;
	logic [acsl_pkg::RESULT_W-1:0] sar_code;
	logic [acsl_pkg::RESULT_W-1:0] sar_decided;

	localparam logic [acsl_pkg::CNT_W-1:0] LAST_CNT =
		acsl_pkg::CNT_W'(acsl_pkg::CONV_CYCLES - 1);
	localparam logic [acsl_pkg::CNT_W-1:0] SAMPLE_END =
		acsl_pkg::CNT_W'(acsl_pkg::SAMPLE_CYCLES - 1);
	localparam logic [acsl_pkg::CNT_W-1:0] TRIAL_LEN =
		acsl_pkg::CNT_W'(acsl_pkg::TRIAL_CYCLES);

	// trial position within the decision phase
	wire [acsl_pkg::CNT_W-1:0] trial_off =
		cnt_reg - acsl_pkg::CNT_W'(acsl_pkg::SAMPLE_CYCLES);
	wire [acsl_pkg::CNT_W-1:0] trial_num = trial_off / TRIAL_LEN;
	wire [acsl_pkg::CNT_W-1:0] trial_pos = trial_off % TRIAL_LEN;
	wire [2:0] bit_idx = 3'(acsl_pkg::RESULT_W - 1) - trial_num[2:0];

	wire in_trial = (state_reg == acsl_pkg::ACSL_TRIAL);
	wire sar_start = (state_reg == acsl_pkg::ACSL_SAMPLE)
		&& (cnt_reg == SAMPLE_END) && !wr_ctrl;
	wire sar_decide = in_trial && (trial_pos == TRIAL_LEN - 1'b1)
		&& !wr_ctrl;
	// conversion ends on the last decision of the 64-cycle frame
	wire conv_done = sar_decide && (cnt_reg == LAST_CNT);

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg + 1'b1;
		if (wr_ctrl)
		begin
			// abort; restart on the new settings if the power bit is set, else go idle
			cnt_next = '0;
			state_next = wdata[acsl_pkg::POWER_BIT] ?
				acsl_pkg::ACSL_SAMPLE : acsl_pkg::ACSL_IDLE;
		end
		else if (!power_reg)
		begin
			cnt_next = '0;
			state_next = acsl_pkg::ACSL_IDLE;
		end
		else
		begin
			unique case (state_reg)
				acsl_pkg::ACSL_IDLE:
				begin
					cnt_next = '0;
					state_next = acsl_pkg::ACSL_SAMPLE;
				end
				acsl_pkg::ACSL_SAMPLE:
				begin
					if (cnt_reg == SAMPLE_END)
						state_next = acsl_pkg::ACSL_TRIAL;
				end
				acsl_pkg::ACSL_TRIAL:
				begin
					if (cnt_reg == LAST_CNT)
					begin
						// back to back, no idle gap
						cnt_next = '0;
						state_next = acsl_pkg::ACSL_SAMPLE;
					end
				end
				default:
				begin
					cnt_next = '0;
					state_next = acsl_pkg::ACSL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge srst_b)
	begin
		if (!srst_b)
		begin
			state_reg <= acsl_pkg::ACSL_IDLE;
			cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	acsl_sar
	#(
		.WIDTH(acsl_pkg::RESULT_W)
	)
	u_sar
	(
		.mclk(mclk),
		.rst_b(srst_b),
		.start(sar_start),
		.decide(sar_decide),
		.bit_idx(bit_idx),
		.comp_high(comp_high),
		.code(sar_code),
		.decided(sar_decided)
	);

	// ----------------------------------------------------------------
	// result and done flag
	// ----------------------------------------------------------------
	// comparator high on every trial ends at all ones, never wraps
	assign result_next = conv_done ? sar_decided : result_reg;
	// set wins over a clear by a result read in the same cycle
	assign done_next = conv_done ? 1'b1 :
		(rd_result || wr_ctrl) ? 1'b0 : done_reg;
	assign evt_next = conv_done ? 1'b1 :
		(wr_status && wdata[acsl_pkg::EVT_DONE_BIT]) ? 1'b0 : evt_reg;

	always_ff @(posedge mclk or negedge srst_b)
	begin
		if (!srst_b)
		begin
			result_reg <= acsl_pkg::RESULT_RESET;
			done_reg <= acsl_pkg::CTRL_RESET[acsl_pkg::DONE_BIT];
			evt_reg <= acsl_pkg::EVT_RESET[acsl_pkg::EVT_DONE_BIT];
			mask_reg <= acsl_pkg::EVT_RESET[acsl_pkg::EVT_DONE_BIT];
		end
		else
		begin
			result_reg <= result_next;
			done_reg <= done_next;
			evt_reg <= evt_next;
			if (wr_mask)
				mask_reg <= wdata[acsl_pkg::EVT_DONE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] ctrl_view;

	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[acsl_pkg::DONE_BIT] = done_reg;
		ctrl_view[acsl_pkg::POWER_BIT] = power_reg;
		// reserved bits never store what software writes
		ctrl_view[acsl_pkg::ZERO_BIT] = 1'b0;
		ctrl_view[acsl_pkg::CHAN_MSB:acsl_pkg::CHAN_LSB] = chan_reg;
	end

	wire [7:0] rd_mux =
		sel_result ? result_reg :
		sel_ctrl ? ctrl_view :
		sel_status ? {7'h00, evt_reg} :
		sel_mask ? {7'h00, mask_reg} : 8'h00;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge srst_b)
	begin
		if (!srst_b)
		begin
			rdata <= 8'h00;
			irq <= 1'b0;
			conv_power_on <= 1'b0;
			input_channel_select <= '0;
			sample_hold <= 1'b0;
			trial_code <= '0;
		end
		else
		begin
			rdata <= rd_en ? rd_mux : 8'h00;
			irq <= evt_next && mask_reg;
			conv_power_on <= power_reg;
			input_channel_select <= chan_reg;
			sample_hold <= (state_next == acsl_pkg::ACSL_SAMPLE);
			trial_code <= sar_code;
		end
	end

endmodule : acsl_top

// ==== acsl_conv_model.sv ====
// acsl_conv_model: analog input mux and comparator beside the converter
`timescale 1ns/10ps
module acsl_conv_model
(
	input wire logic mclk,
	input wire logic sample_hold,
	input wire logic [acsl_pkg::CHAN_W-1:0] input_channel_select,
	input wire logic [7:0] trial_code,
	input wire logic [63:0] level,
	output logic comp_high
);
	logic [7:0] held_reg;
	// the level is tracked while sampling and frozen once sampling ends, as a hold capacitor would
	always_ff @(posedge mclk)
	begin
		if (sample_hold)
			held_reg <= level[input_channel_select*8 +: 8];
	end
	// a saturated input compares high on every trial, no overflow
	assign comp_high = held_reg >= trial_code;
endmodule : acsl_conv_model

// ==== acsl_top_assertions.sv ====
// acsl_top_assertions: port checks of the converter control block
`timescale 1ns/10ps
module acsl_top_assertions
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic conv_power_on,
	input wire logic [acsl_pkg::CHAN_W-1:0] input_channel_select,
	input wire logic sample_hold,
	input wire logic [7:0] trial_code,
	input wire logic comp_high
);
	wire wc = wr_en && addr == acsl_pkg::CTRL_OFS;
	wire rc = rd_en && addr == acsl_pkg::CTRL_OFS;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_power;
		wc |=> ##1 conv_power_on == $past(wdata[5], 2);
	endproperty
	a_power: assert property (p_power) else $error("power copy");
	property p_chan;
		wc |=> ##1 input_channel_select == $past(wdata[2:0], 2);
	endproperty
	a_chan: assert property (p_chan) else $error("channel copy");
	property p_rsvd;
		rc |=> !rdata[6] && !rdata[4] && !rdata[3];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_idle;
		!$past(rd_en) |-> rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("stray rdata");
	property p_start;
		wc && wdata[5] |-> ##[1:3] sample_hold;
	endproperty
	a_start: assert property (p_start) else $error("no restart");
	// a write in the previous cycle may cut sampling short
	property p_trial;
		$fell(sample_hold) && conv_power_on && !$past(wr_en)
			|-> ##1 trial_code == 8'h80;
	endproperty
	a_trial: assert property (p_trial) else $error("first trial");
	property p_off;
		!conv_power_on && !$past(conv_power_on) && !$past(wr_en)
			|-> !sample_hold;
	endproperty
	a_off: assert property (p_off) else $error("sampling off");
	property p_irq;
		$fell(irq) |-> $past(wr_en) || $past(wr_en, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq dropped");
endmodule : acsl_top_assertions
bind acsl_top acsl_top_assertions u_acsl_top_assertions (.mclk(mclk),
	.rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .irq(irq), .conv_power_on(conv_power_on),
	.input_channel_select(input_channel_select), .sample_hold(sample_hold),
	.trial_code(trial_code), .comp_high(comp_high));

// ==== test_acsl_top.sv ====
// test_acsl_top: self-checking bench of the converter control block
`timescale 1ns/10ps
module test_acsl_top;
	logic mclk, rst_b, wr_en, rd_en, comp_high, irq, sample_hold, pwr;
	logic [7:0] addr, wdata, rdata, trial_code, d;
	logic [acsl_pkg::CHAN_W-1:0] sel;
	logic [63:0] level;
	int fail_count, tests_run, cyc, t0;
	acsl_top u_acsl_top (.mclk(mclk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.irq(irq), .conv_power_on(pwr), .input_channel_select(sel),
		.sample_hold(sample_hold), .trial_code(trial_code),
		.comp_high(comp_high));
	acsl_conv_model u_acsl_conv_model (.mclk(mclk), .sample_hold(sample_hold),
		.input_channel_select(sel), .trial_code(trial_code), .level(level),
		.comp_high(comp_high));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// polls the done flag; a bounded count so a dead sequencer cannot hang
	task automatic wait_done();
		int n;
		n = 0;
		rd(acsl_pkg::CTRL_OFS);
		while (d[7] !== 1'b1 && n < 200)
		begin
			rd(acsl_pkg::CTRL_OFS);
			n++;
		end
	endtask : wait_done
	task automatic t_reset();
		for (int a = 8'h0A; a < 8'h0F; a++)
		begin
			rd(8'(a));
			chk(d, 8'h00);
		end
		wr(8'h00, 8'hFF);
		rd(8'h00);
		chk(d, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_conv();
		wr(acsl_pkg::EVT_MASK_OFS, 8'h01);
		wr(acsl_pkg::CTRL_OFS, 8'h20);
		repeat (6000) @(posedge mclk);
		for (int ch = 0; ch < 8; ch++)
		begin
			wr(acsl_pkg::CTRL_OFS, 8'(8'h20 + ch));
			t0 = cyc;
			// the pin copies trail the register by one clock
			@(posedge mclk);
			#1 chk({4'h0, pwr, sel}, 8'(8'h08 + ch));
			wait_done();
			chk(8'(cyc - t0 > 61 && cyc - t0 < 73), 8'h01);
			chk(d & 8'hF8, 8'hA0);
			chk({7'h00, irq}, 8'h01);
			rd(acsl_pkg::RESULT_OFS);
			chk(d, level[ch*8 +: 8]);
			rd(acsl_pkg::CTRL_OFS);
			chk(d, 8'(8'h20 + ch));
			wr(acsl_pkg::EVT_STATUS_OFS, 8'h01);
			rd(acsl_pkg::EVT_STATUS_OFS);
			chk(d, 8'h00);
			chk({7'h00, irq}, 8'h00);
		end
		$display("conversion test done");
	endtask : t_conv
	task automatic t_abort();
		wait_done();
		wr(acsl_pkg::CTRL_OFS, 8'h31);
		rd(acsl_pkg::CTRL_OFS);
		chk(d, 8'h21);
		wait_done();
		rd(acsl_pkg::RESULT_OFS);
		chk(d, 8'hFF);
		$display("abort test done");
	endtask : t_abort
	task automatic t_repeat();
		level[15:8] <= 8'h3C;
		wr(acsl_pkg::EVT_MASK_OFS, 8'h00);
		wr(acsl_pkg::EVT_STATUS_OFS, 8'h01);
		wait_done();
		rd(acsl_pkg::RESULT_OFS);
		wait_done();
		rd(acsl_pkg::RESULT_OFS);
		chk(d, 8'h3C);
		chk({7'h00, irq}, 8'h00);
		rd(acsl_pkg::EVT_STATUS_OFS);
		chk(d, 8'h01);
		$display("repeat test done");
	endtask : t_repeat
	task automatic t_off();
		wr(acsl_pkg::CTRL_OFS, 8'h01);
		repeat (150) @(posedge mclk);
		rd(acsl_pkg::CTRL_OFS);
		chk(d, 8'h01);
		rd(acsl_pkg::RESULT_OFS);
		chk(d, 8'h3C);
		$display("power off test done");
	endtask : t_off
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial
	begin
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		level = 64'hFE7F_8001_AA55_FF00;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_conv();
		t_abort();
		t_repeat();
		t_off();
		print_verdict();
	end
endmodule : test_acsl_top
